// [verilog/mtap_pkg.sv]
// Constants, object indices and carrier types for the multiturn absolute position block
// ------------------------------
// Operation
// - Revolution count goes down turning clockwise, up turning counter-clockwise.
// - Multiturn linear mode keeps a signed count from -32768 to +32767.
// - Passing +32767 wraps to -32768 and counting goes on; mirrored clockwise.
// - In-turn position is unsigned, 0..131071 at 17 bits, 0..8388607 at 23.
// - Multiturn linear mode with invalid stored position raises the encoder alarm.
// - Alarm clears once homing is established, mode 9 is written and the battery shows no fault.
// - Rotational mode keeps the multiturn value within the upper limit, never overflows.
// - Single-turn targets span one turn, shifted by the home offset as soon as it is written.
// - Writing mode 9 zeroes the revolution count, keeps position, clears the invalid-position alarm once homed.
// - Single-turn operation limits motion to one turn from the power-on position.
// - Battery below 3.2v raises the alarm; cleared by replacement and restart.
// - Battery below 2.5v or lost keeps the alarm until homing and clearing.
// - While the encoder alarm is active all motion is suspended.
// - Alarm shows on the panel, the alarm output pin and to the controller.
// - Two probe inputs work at once, latching position on rising and falling edges.
// ------------------------------
package mtap_pkg;

    // ------------------------------
    // Object indices
    // ------------------------------
    localparam logic [15:0] IDX_PROBE_POL    = 16'h2007;
    localparam logic [15:0] IDX_ENC_MODE     = 16'h2015;
    localparam logic [15:0] IDX_MT_LIMIT     = 16'h2663;
    localparam logic [15:0] IDX_ALARM_STAT   = 16'h2700;
    localparam logic [15:0] IDX_ACT_POS      = 16'h6064;
    localparam logic [15:0] IDX_HOME_OFFSET  = 16'h607C;
    localparam logic [15:0] IDX_PROBE_STAT   = 16'h60B9;
    localparam logic [15:0] IDX_P1_RISE      = 16'h60BA;
    localparam logic [15:0] IDX_P1_FALL      = 16'h60BB;
    localparam logic [15:0] IDX_P2_RISE      = 16'h60BC;
    localparam logic [15:0] IDX_P2_FALL      = 16'h60BD;

    // ------------------------------
    // Reset values and widths
    // ------------------------------
    localparam logic [15:0] PROBE_POL_RESET  = 16'h0003;
    localparam logic [15:0] ENC_MODE_RESET   = 16'h0000;
    localparam logic [15:0] MT_LIMIT_RESET   = 16'h0000;
    localparam int          ENC_BITS_DEF     = 23;
    localparam int          SYNC_STAGES      = 2;

    // Encoder mode codes
    localparam logic [15:0] MODE_INCR        = 16'h0000;
    localparam logic [15:0] MODE_MT_LINEAR   = 16'h0001;
    localparam logic [15:0] MODE_MT_ROTARY   = 16'h0002;
    localparam logic [15:0] MODE_SINGLE      = 16'h0003;
    localparam logic [15:0] MODE_CLEAR_MT    = 16'h0009;

    // Polarity field positions: a zero bit inverts that probe
    localparam int          POL_BIT_P1       = 0;
    localparam int          POL_BIT_P2       = 1;
    localparam int          NUM_PROBES       = 2;

    // ------------------------------
    // Carrier types
    // ------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } mtap_obj_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } mtap_obj_rsp_t;

    typedef struct packed {
        logic        batt_low;
        logic        batt_fail;
        logic        backup_lost;
        logic        probe_two;
        logic        probe_one;
    } mtap_pins_t;

endpackage

// [verilog/mtap_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module mtap_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import mtap_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second; nothing else looks at it
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [verilog/mtap_probe.sv]
// One probe channel: edge detect on a synchronised level and position latching
`timescale 1ns/1ps
module mtap_probe (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        level_in,
    input  wire logic        invert,
    input  wire logic [31:0] position,
    input  wire logic        flag_clear,
    output logic      [31:0] rise_pos_q,
    output logic      [31:0] fall_pos_q,
    output logic             rise_flag_q,
    output logic             fall_flag_q
);
    import mtap_pkg::*;

    logic level_q;
    logic level_d;
    logic rise;
    logic fall;

    assign level_d = level_in ^ invert;
    assign rise    = level_d & ~level_q;
    assign fall    = ~level_d & level_q;

    // Previous level; starts low so an input high at reset counts as a rising edge
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    // Latch feedback position on each edge, both edges independently
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rise_pos_q <= 32'h0000_0000;
            fall_pos_q <= 32'h0000_0000;
        end else begin
            if (rise) begin
                rise_pos_q <= position;
            end
            if (fall) begin
                fall_pos_q <= position;
            end
        end
    end

    // Edge flags: a new edge wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else begin
            rise_flag_q <= rise | (rise_flag_q & ~flag_clear);
            fall_flag_q <= fall | (fall_flag_q & ~flag_clear);
        end
    end
endmodule

// [verilog/mtap_top.sv]
// Multiturn absolute position tracking, encoder alarm and probe latching
`timescale 1ns/1ps
module mtap_top #(
    parameter int ENC_BITS = mtap_pkg::ENC_BITS_DEF
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire mtap_pkg::mtap_obj_req_t obj_req,
    output mtap_pkg::mtap_obj_rsp_t    obj_rsp_q,
    input  wire mtap_pkg::mtap_pins_t  pins,
    input  wire logic                  enc_sample,
    input  wire logic [ENC_BITS-1:0]   enc_pos,
    input  wire logic                  homing_done,
    input  wire logic                  restart_req,
    input  wire logic [31:0]           target_pos,
    output logic                       alarm_output_pin_q,
    output logic                       panel_alarm_q,
    output logic                       motion_enable_q,
    output logic                       target_ok_q,
    output logic                       turn_limit_q,
    output logic signed [15:0]         rev_count_q,
    output logic [15:0]                rotary_count_q,
    output logic [ENC_BITS-1:0]        in_turn_q
);
    import mtap_pkg::*;

    // ------------------------------
    // Pin synchronisation
    // ------------------------------
    mtap_pins_t pins_s;

    mtap_sync #(
        .WIDTH    ($bits(mtap_pins_t))
    ) u_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (pins),
        .sync_out (pins_s)
    );

    // ------------------------------
    // Object registers
    // ------------------------------
    logic [15:0]        probe_pol_q;
    logic [1:0]         pol_active_q;
    logic [15:0]        enc_mode_q;
    logic [15:0]        mt_limit_q;
    logic [31:0]        home_offset_q;
    logic               wr_mode;
    logic               clear_mt;

    assign wr_mode  = obj_req.wr && (obj_req.index == IDX_ENC_MODE);
    assign clear_mt = wr_mode && (obj_req.wdata[15:0] == MODE_CLEAR_MT);

    // Parameter writes; mode 9 is a command and leaves the stored mode alone
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            probe_pol_q   <= PROBE_POL_RESET;
            enc_mode_q    <= ENC_MODE_RESET;
            mt_limit_q    <= MT_LIMIT_RESET;
            home_offset_q <= 32'h0000_0000;
        end else if (obj_req.wr) begin
            case (obj_req.index)
                IDX_PROBE_POL:   probe_pol_q   <= obj_req.wdata[15:0];
                IDX_ENC_MODE:    if (!clear_mt) enc_mode_q <= obj_req.wdata[15:0];
                IDX_MT_LIMIT:    mt_limit_q    <= obj_req.wdata[15:0];
                IDX_HOME_OFFSET: home_offset_q <= obj_req.wdata;
                default:         ;
            endcase
        end
    end

    // Polarity only takes effect at a restart, so a live write cannot glitch a probe
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pol_active_q <= PROBE_POL_RESET[1:0];
        end else if (restart_req) begin
            pol_active_q <= probe_pol_q[1:0];
        end
    end

    // ------------------------------
    // Revolution tracking
    // ------------------------------
    logic [1:0] quad_prev;
    logic [1:0] quad_new;
    logic       step_ccw;
    logic       step_cw;
    logic       seen_q;

    assign quad_prev = in_turn_q[ENC_BITS-1 -: 2];
    assign quad_new  = enc_pos[ENC_BITS-1 -: 2];
    // A jump across the top quadrant boundary is a full-turn crossing
    assign step_ccw  = enc_sample && seen_q && (quad_prev == 2'b11) && (quad_new == 2'b00);
    assign step_cw   = enc_sample && seen_q && (quad_prev == 2'b00) && (quad_new == 2'b11);

    // In-turn position, unsigned, width set by encoder resolution
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            in_turn_q <= '0;
            seen_q    <= 1'b0;
        end else if (enc_sample) begin
            in_turn_q <= enc_pos;
            seen_q    <= 1'b1;
        end
    end

    // Signed count; 16-bit arithmetic wraps +32767 to -32768 and back
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rev_count_q <= 16'sh0000;
        end else if (clear_mt) begin
            rev_count_q <= 16'sh0000;
        end else if (step_ccw) begin
            rev_count_q <= rev_count_q + 16'sh0001;
        end else if (step_cw) begin
            rev_count_q <= rev_count_q - 16'sh0001;
        end
    end

    // Rotational count stays within 0..limit whatever the direction
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rotary_count_q <= 16'h0000;
        end else if (clear_mt) begin
            rotary_count_q <= 16'h0000;
        end else if (step_ccw) begin
            rotary_count_q <= (rotary_count_q >= mt_limit_q) ? 16'h0000
                                                             : rotary_count_q + 16'h0001;
        end else if (step_cw) begin
            rotary_count_q <= (rotary_count_q == 16'h0000) ? mt_limit_q
                                                           : rotary_count_q - 16'h0001;
        end
    end

    // ------------------------------
    // Single-turn window
    // ------------------------------
    logic signed [15:0] rev_pwr_q;
    logic               pwr_taken_q;
    logic [31:0]        turn_span;
    logic [31:0]        tgt_rel;

    // Capture the count at the first sample after power-on as the turn origin
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rev_pwr_q   <= 16'sh0000;
            pwr_taken_q <= 1'b0;
        end else if (!pwr_taken_q && seen_q) begin
            rev_pwr_q   <= rev_count_q;
            pwr_taken_q <= 1'b1;
        end
    end

    assign turn_span = 32'((64'd1 << ENC_BITS) - 64'd1);
    assign tgt_rel   = target_pos - home_offset_q;

    // Leaving the power-on turn in single-turn mode stops motion
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            turn_limit_q <= 1'b0;
        end else begin
            turn_limit_q <= (enc_mode_q == MODE_SINGLE) && pwr_taken_q
                            && (rev_count_q != rev_pwr_q);
        end
    end

    // Target window is [offset, offset + one turn - 1]; unsigned wrap handles the shift
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            target_ok_q <= 1'b0;
        end else if (enc_mode_q == MODE_SINGLE) begin
            target_ok_q <= (tgt_rel <= turn_span);
        end else begin
            target_ok_q <= 1'b1;
        end
    end

    // ------------------------------
    // Encoder alarm
    // ------------------------------
    logic invalid_q;
    logic low_q;
    logic homed_q;
    logic abs_mode;
    logic alarm_d;

    assign abs_mode = (enc_mode_q == MODE_MT_LINEAR) || (enc_mode_q == MODE_MT_ROTARY);

    // Homing must be seen before a clear can validate the data
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            homed_q <= 1'b0;
        end else if (homing_done) begin
            homed_q <= 1'b1;
        end
    end

    // Lost backup data or deep discharge sticks until homing plus a multiturn clear;
    // a fault present in the same cycle as the clear wins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            invalid_q <= 1'b0;
        end else if (pins_s.backup_lost || pins_s.batt_fail) begin
            invalid_q <= 1'b1;
        end else if (clear_mt && homed_q && !pins_s.batt_low) begin
            invalid_q <= 1'b0;
        end
    end

    // Low battery sticks until restart; reset is the only way out
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            low_q <= 1'b0;
        end else if (pins_s.batt_low) begin
            low_q <= 1'b1;
        end
    end

    assign alarm_d = abs_mode && (invalid_q || low_q);

    // Same alarm drives panel, pin and the controller status object
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            alarm_output_pin_q <= 1'b0;
            panel_alarm_q      <= 1'b0;
            motion_enable_q    <= 1'b0;
        end else begin
            alarm_output_pin_q <= alarm_d;
            panel_alarm_q      <= alarm_d;
            motion_enable_q    <= !alarm_d && !turn_limit_q;
        end
    end

    // ------------------------------
    // Probes
    // ------------------------------
    logic [31:0] fb_pos;
    logic [NUM_PROBES-1:0] probe_lvl;
    logic [NUM_PROBES-1:0] probe_inv;
    logic [31:0] p_rise [NUM_PROBES];
    logic [31:0] p_fall [NUM_PROBES];
    logic [NUM_PROBES-1:0] p_rflag;
    logic [NUM_PROBES-1:0] p_fflag;
    logic        stat_rd;

    // Feedback position: count in the upper bits, in-turn position below
    assign fb_pos    = 32'({rev_count_q, in_turn_q});
    assign probe_lvl = {pins_s.probe_two, pins_s.probe_one};
    // A zero polarity bit inverts that probe
    assign probe_inv = {~pol_active_q[POL_BIT_P2], ~pol_active_q[POL_BIT_P1]};
    // Reading the probe status clears its edge flags
    assign stat_rd   = obj_req.rd && (obj_req.index == IDX_PROBE_STAT);

    generate
        for (genvar i = 0; i < NUM_PROBES; i++) begin : g_probe
            mtap_probe u_probe (
                .ref_clk     (ref_clk),
                .reset_n     (reset_n),
                .level_in    (probe_lvl[i]),
                .invert      (probe_inv[i]),
                .position    (fb_pos),
                .flag_clear  (stat_rd),
                .rise_pos_q  (p_rise[i]),
                .fall_pos_q  (p_fall[i]),
                .rise_flag_q (p_rflag[i]),
                .fall_flag_q (p_fflag[i])
            );
        end
    endgenerate

    // ------------------------------
    // Object reads
    // ------------------------------
    logic [31:0] rd_mux;

    // Unknown indices read as zero
    always_comb begin
        case (obj_req.index)
            IDX_PROBE_POL:   rd_mux = {16'h0000, probe_pol_q};
            IDX_ENC_MODE:    rd_mux = {16'h0000, enc_mode_q};
            IDX_MT_LIMIT:    rd_mux = {16'h0000, mt_limit_q};
            IDX_HOME_OFFSET: rd_mux = home_offset_q;
            IDX_ACT_POS:     rd_mux = (enc_mode_q == MODE_MT_ROTARY)
                                      ? 32'({rotary_count_q, in_turn_q}) : fb_pos;
            IDX_ALARM_STAT:  rd_mux = {28'h000_0000, homed_q, low_q, invalid_q, alarm_d};
            IDX_PROBE_STAT:  rd_mux = {22'h00_0000, p_fflag[1], p_rflag[1], 6'h00,
                                       p_fflag[0], p_rflag[0]};
            IDX_P1_RISE:     rd_mux = p_rise[0];
            IDX_P1_FALL:     rd_mux = p_fall[0];
            IDX_P2_RISE:     rd_mux = p_rise[1];
            IDX_P2_FALL:     rd_mux = p_fall[1];
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Read answer one cycle after the request; the position is a live snapshot,
    // so the controller must read at standstill and compare two reads
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            obj_rsp_q <= '0;
        end else begin
            obj_rsp_q.valid <= obj_req.rd;
            obj_rsp_q.rdata <= obj_req.rd ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

// [test/mtap_monitor.sv]
// Port checker for the multiturn absolute position block
`timescale 1ns/1ps
module mtap_monitor
    import mtap_pkg::*;
#(
    parameter int ENC_BITS = 23
) (
    input wire logic                    ref_clk,
    input wire logic                    reset_n,
    input wire mtap_pkg::mtap_obj_req_t obj_req,
    input wire mtap_pkg::mtap_obj_rsp_t obj_rsp_q,
    input wire logic                    enc_sample,
    input wire logic [ENC_BITS-1:0]     enc_pos,
    input wire logic                    homing_done,
    input wire logic                    alarm_output_pin_q,
    input wire logic                    panel_alarm_q,
    input wire logic                    motion_enable_q,
    input wire logic signed [15:0]      rev_count_q,
    input wire logic [ENC_BITS-1:0]     in_turn_q
);
    logic signed [15:0]  prev_rev_q;
    logic [ENC_BITS-1:0] last_pos_q;
    logic [1:0]          quiet_q;
    logic [2:0]          clr_age_q;
    logic                mode_wr;

    assign mode_wr = obj_req.wr && (obj_req.index == IDX_ENC_MODE);

    // Quiet time since a count cause; a count lands on the same edge that sees its cause
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            prev_rev_q <= '0;
            last_pos_q <= '0;
            quiet_q    <= '0;
            clr_age_q  <= '0;
        end else begin
            prev_rev_q <= rev_count_q;
            if (enc_sample) begin
                last_pos_q <= enc_pos;
            end
            quiet_q   <= (enc_sample || mode_wr) ? 2'd0 : quiet_q + {1'b0, quiet_q != 2'd3};
            clr_age_q <= (mode_wr || homing_done) ? 3'd0 : clr_age_q + {2'b0, clr_age_q != 3'd7};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    alarm_pins_a: assert property (alarm_output_pin_q == panel_alarm_q)
        else $error("alarm pin and panel alarm differ");
    motion_stop_a: assert property (alarm_output_pin_q && $past(alarm_output_pin_q)
        |-> !motion_enable_q) else $error("motion allowed under alarm");
    rev_step_a: assert property (rev_count_q != prev_rev_q |->
        rev_count_q == prev_rev_q + 16'sd1 || rev_count_q == prev_rev_q - 16'sd1
        || rev_count_q == 16'sd0) else $error("revolution count jumped");
    rev_hold_a: assert property (quiet_q == 2'd3 |-> $stable(rev_count_q))
        else $error("revolution count moved without a sample");
    in_turn_a: assert property (quiet_q == 2'd3 |-> in_turn_q == last_pos_q)
        else $error("in-turn position not the last sample");
    rsp_timing_a: assert property (obj_req.rd |=> obj_rsp_q.valid)
        else $error("read not answered");
    rsp_idle_a: assert property (!$past(obj_req.rd) |->
        !obj_rsp_q.valid && obj_rsp_q.rdata == '0) else $error("answer without a read");
    alarm_clear_a: assert property ($fell(alarm_output_pin_q) |-> clr_age_q < 3'd4)
        else $error("alarm cleared without homing or mode write");

    cover property ($fell(alarm_output_pin_q));
    cover property (rev_count_q == -16'sd1);
    cover property (obj_rsp_q.valid && obj_rsp_q.rdata != '0);
endmodule

// [test/mtap_ctl_model.sv]
// Motion controller model issuing object requests and homing
`timescale 1ns/1ps
module mtap_ctl_model
    import mtap_pkg::*;
(
    input  wire logic               ref_clk,
    output mtap_pkg::mtap_obj_req_t obj_req,
    output logic                    homing_done
);
    initial begin
        obj_req = '0;
        homing_done = 1'b0;
    end
    // One-cycle strobe; idle index and data are scrambled so nothing leans on them
    task automatic xfer(logic w, logic [15:0] idx, logic [31:0] d);
        @(negedge ref_clk);
        obj_req <= '{w, !w, idx, d};
        @(negedge ref_clk);
        obj_req <= '{1'b0, 1'b0, ~idx, ~d};
    endtask
    // Homing pulse
    task automatic home();
        @(negedge ref_clk);
        homing_done <= 1'b1;
        @(negedge ref_clk);
        homing_done <= 1'b0;
    endtask
    // Clearing is only asked for on an axis homed within one turn
    task automatic clear_mt();
        home();
        xfer(1'b1, IDX_ENC_MODE, {16'h0000, MODE_CLEAR_MT});
    endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the multiturn absolute position block
`timescale 1ns/1ps
module testbench;
    import mtap_pkg::*;
    localparam int EB = 23;
    localparam logic [31:0] TD[4] = '{32'hffff_ffff, 32'h0000_0000, 32'h007f_ffff, 32'h0080_0000};
    logic               ref_clk, reset_n, enc_sample, homing_done, restart_req;
    logic               alarm_output_pin, pnl, mot, tok, tlim;
    logic [EB-1:0]      enc_pos, in_q, in_e;
    logic [31:0]        target_pos, seed, r;
    logic signed [15:0] rev_q, rev_e;
    logic [15:0]        rot_q, rot_e;
    logic [63:0]        x;
    mtap_obj_req_t      obj_req;
    mtap_obj_rsp_t      obj_rsp_q;
    mtap_pins_t         pins;
    logic [63:0]        exp_q[$];
    int                 num_errors, total_checks;

    mtap_top #(.ENC_BITS(EB)) uut (.ref_clk, .reset_n, .obj_req, .obj_rsp_q, .pins,
        .enc_sample, .enc_pos, .homing_done, .restart_req, .target_pos,
        .alarm_output_pin_q(alarm_output_pin), .panel_alarm_q(pnl), .motion_enable_q(mot),
        .target_ok_q(tok), .turn_limit_q(tlim), .rev_count_q(rev_q),
        .rotary_count_q(rot_q), .in_turn_q(in_q));
    mtap_ctl_model ctl (.ref_clk, .obj_req, .homing_done);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] pos();
        return 32'({rev_e, in_e});
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Expected answer is queued before the read goes out
    task automatic rdc(logic [15:0] idx, logic [31:0] e, logic [31:0] m = 32'hffff_ffff);
        exp_q.push_back({m, e});
        ctl.xfer(1'b0, idx, 32'h0000_0000);
    endtask
    task automatic rst(int n);
        reset_n <= 1'b0;
        cyc(n);
        reset_n <= 1'b1;
        rev_e = 0;
        rot_e = 0;
    endtask
    // Encoder sample; position is scrambled while not qualified
    task automatic smp(logic [1:0] qd);
        r = xs();
        @(negedge ref_clk);
        enc_pos <= {qd, r[EB-3:0]};
        in_e = {qd, r[EB-3:0]};
        enc_sample <= 1'b1;
        @(negedge ref_clk);
        enc_sample <= 1'b0;
        enc_pos <= ~in_e;
        cyc(2);
    endtask
    task automatic spin(logic ccw);
        for (int k = 1; k < 5; k++) smp(ccw ? k[1:0] : 2'(4 - k));
        rev_e = ccw ? rev_e + 16'sd1 : rev_e - 16'sd1;
        rot_e = (rot_e + (ccw ? 16'd1 : 16'd3)) % 16'd4;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Answer watcher: oldest note against each valid answer
    always @(negedge ref_clk) begin
        if (obj_rsp_q.valid === 1'b1) begin
            x = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h1;
            chk("rdata", x[31:0], obj_rsp_q.rdata & x[63:32]);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end

    initial begin
        seed = 32'h5a45;
        {enc_sample, restart_req, reset_n} = '0;
        enc_pos = '0;
        target_pos = '0;
        pins = '0;
        rst(10);
        smp(2'd0);
        rdc(IDX_PROBE_POL, 32'h3);
        rdc(16'h1234, 32'h0);
        rdc(IDX_ACT_POS, pos());
        // Invalid stored position, then home and clear
        pins.backup_lost <= 1'b1;
        ctl.xfer(1'b1, IDX_ENC_MODE, 32'h1);
        cyc(6);
        chk("alarm", 32'h6, 32'({alarm_output_pin, pnl, mot}));
        rdc(IDX_ALARM_STAT, 32'h1, 32'h1);
        pins.backup_lost <= 1'b0;
        ctl.clear_mt();
        cyc(6);
        chk("alarm", 32'h1, 32'({alarm_output_pin, pnl, mot}));
        for (int i = 0; i < 20; i++) begin
            r = xs();
            spin(r[0]);
            cyc(1);
            chk("rev", 32'(rev_e), 32'(rev_q));
            chk("in turn", 32'(in_e), 32'(in_q));
        end
        rdc(IDX_ACT_POS, pos());
        rdc(IDX_ACT_POS, pos());
        ctl.clear_mt();
        rev_e = 0;
        rdc(IDX_ACT_POS, pos());
        // Battery faults: hard fault clears by homing plus a multiturn clear, low battery needs a restart
        for (int f = 0; f < 2; f++) begin
            pins <= f ? 5'b10000 : 5'b01000;
            cyc(6);
            pins <= '0;
            cyc(6);
            chk("held alarm", 32'h1, 32'(alarm_output_pin));
            ctl.clear_mt();
            cyc(6);
            chk("alarm after clear", 32'(f), 32'(alarm_output_pin));
        end
        rst(2);
        cyc(3);
        chk("alarm after restart", 32'h0, 32'(alarm_output_pin));
        smp(2'd0);
        ctl.xfer(1'b1, IDX_MT_LIMIT, 32'h3);
        ctl.xfer(1'b1, IDX_ENC_MODE, 32'h2);
        for (int i = 0; i < 12; i++) begin
            r = xs();
            spin(r[0]);
            cyc(1);
            chk("rotary", 32'(rot_e), 32'(rot_q));
        end
        // Single-turn window with and without home offset
        rst(2);
        smp(2'd0);
        ctl.xfer(1'b1, IDX_ENC_MODE, 32'h3);
        for (int o = 0; o < 2; o++) begin
            ctl.xfer(1'b1, IDX_HOME_OFFSET, 32'(o * 10000));
            ctl.home();
            for (int t = 0; t < 4; t++) begin
                target_pos <= 32'(o * 10000) + TD[t];
                cyc(4);
                chk("target ok", 32'(t == 1 || t == 2), 32'(tok));
            end
        end
        chk("turn limit", 32'h0, 32'(tlim));
        spin(1'b1);
        cyc(1);
        chk("turn limit", 32'h1, 32'(tlim));
        // Probe edges, read-to-clear, then polarity applied by restart
        pins.probe_one <= 1'b1;
        cyc(6);
        pins.probe_one <= 1'b0;
        cyc(6);
        pins.probe_two <= 1'b1;
        cyc(6);
        rdc(IDX_PROBE_STAT, 32'h0103, 32'h0303);
        rdc(IDX_PROBE_STAT, 32'h0, 32'h0303);
        rdc(IDX_P1_RISE, pos());
        rdc(IDX_P2_RISE, pos());
        ctl.xfer(1'b1, IDX_PROBE_POL, 32'h2);
        rdc(IDX_PROBE_POL, 32'h2);
        restart_req <= 1'b1;
        cyc(1);
        restart_req <= 1'b0;
        cyc(6);
        rdc(IDX_PROBE_STAT, 32'h0, 32'h0);
        pins.probe_one <= 1'b1;
        cyc(6);
        rdc(IDX_PROBE_STAT, 32'h2, 32'h3);
        cyc(4);
        chk("pending", 32'h0, 32'(exp_q.size()));
        final_report();
    end
endmodule

bind mtap_top mtap_monitor #(.ENC_BITS(ENC_BITS)) u_mon (.ref_clk, .reset_n, .obj_req,
    .obj_rsp_q, .enc_sample, .enc_pos, .homing_done, .alarm_output_pin_q, .panel_alarm_q,
    .motion_enable_q, .rev_count_q, .in_turn_q);
